/* File: src/bcs_regs.vh */
`ifndef BCS_REGS_VH
`define BCS_REGS_VH
`define BCS_U1_BASE     32'h40051104
`define BCS_U2_BASE     32'h40052104
`define BCS_U1_OFF      14'h1104
`define BCS_U2_OFF      14'h2104
`define BCS_STRIDE      14'h0100
`define BCS_NBR         4
`define BCS_RUN_BIT     0
`define BCS_AUTO_BIT    1
`define BCS_WAKE_BIT    2
`define BCS_RUNN_BIT    5
`define BCS_RUN_RST     1'b1
`define BCS_AUTO_RST    1'b0
`define BCS_WAKE_RST    1'b0
`define BCS_RUNN_RST    1'b0
`endif

/* File: src/bcs_status_mem.v */
`timescale 1ns/100ps
// ----------------------------------------
// Status word store, one per branch
// ----------------------------------------
module bcs_status_mem (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire [7:0]  next_word_vec,
   input  wire [1:0]  rd_idx,
   output reg  [31:0] rd_data
);
`include "bcs_regs.vh"
   reg [1:0] run_q;
   reg [1:0] auto_q;
   reg [1:0] wake_q;
   integer   k;
   // Sample live configuration into status bits
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_q  <= {2{`BCS_RUN_RST}};
         auto_q <= {2{`BCS_AUTO_RST}};
         wake_q <= {2{`BCS_WAKE_RST}};
      end else begin
         for (k = 0; k < 2; k = k + 1) begin
            run_q[k]  <= next_word_vec[4*k];
            auto_q[k] <= next_word_vec[4*k+1];
            wake_q[k] <= next_word_vec[4*k+2];
         end
      end
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_data <= 32'h00000000;
      end else begin
         rd_data <= 32'h00000000;
         rd_data[`BCS_RUN_BIT]  <= run_q[rd_idx[0]];
         rd_data[`BCS_AUTO_BIT] <= auto_q[rd_idx[0]];
         rd_data[`BCS_WAKE_BIT] <= wake_q[rd_idx[0]];
         rd_data[`BCS_RUNN_BIT] <= ~run_q[rd_idx[0]];
      end
   end
endmodule // bcs_status_mem

/* File: src/bcs_branch_cond.v */
`timescale 1ns/100ps
// ----------------------------------------
// Per-branch condition forming
// ----------------------------------------
module bcs_branch_cond (
   input  wire       branch_enable,
   input  wire       auto_disable_en,
   input  wire       wake_run_cfg,
   input  wire       power_down_request,
   output wire [3:0] cond
);
   assign cond = {1'b0,
                  power_down_request & wake_run_cfg,
                  auto_disable_en,
                  branch_enable};
endmodule // bcs_branch_cond

/* File: src/bcs_top.v */
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// ----------------------------------------
// Branch clock status readback, AHB-Lite slave
// ----------------------------------------
module bcs_top (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire [1:0]  branch_enable,
   input  wire [1:0]  auto_disable_en,
   input  wire [1:0]  wake_run_cfg,
   input  wire        power_down_request
);
`include "bcs_regs.vh"
   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function [2:0] dec;   // {hit, unit index}
      input [31:0] a;
      begin
         if (a == `BCS_U1_BASE)
            dec = 3'b100;
         else if (a == `BCS_U2_BASE)
            dec = 3'b101;
         else
            dec = 3'b000;
      end
   endfunction
   wire [7:0]  cond_vec;
   wire [31:0] mem_rd;
   reg  [1:0]  rd_idx;
   reg         ph_rd;
   reg         ph_hit;
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_WAIT1 = 3'b010;
   localparam [2:0] ST_WAIT2 = 3'b100;
   reg  [2:0]  state;
   wire [2:0]  d = dec(haddr);
   wire        take = hsel & hready & htrans[1];
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gen_br
         bcs_branch_cond u_cond (
            .branch_enable      (branch_enable[g]),
            .auto_disable_en    (auto_disable_en[g]),
            .wake_run_cfg       (wake_run_cfg[g]),
            .power_down_request (power_down_request),
            .cond               (cond_vec[4*g+3:4*g])
         );
      end
   endgenerate
   // Divider status is not an input here at all
   bcs_status_mem u_mem (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .next_word_vec (cond_vec),
      .rd_idx        (rd_idx),
      .rd_data       (mem_rd)
   );
   // ----------------------------------------
   // Bus sequencing: two wait states per transfer
   // ----------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_idx    <= 2'b00;
         ph_rd     <= 1'b0;
         ph_hit    <= 1'b0;
         state     <= ST_IDLE;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h00000000;
      end else begin
         hresp <= 1'b0;
         case (state)
            ST_WAIT1: begin
               state <= ST_WAIT2;
            end
            ST_WAIT2: begin
               state     <= ST_IDLE;
               hreadyout <= 1'b1;
               hrdata    <= (ph_rd & ph_hit) ? mem_rd : 32'h00000000;
            end
            default: begin
               state     <= ST_IDLE;
               hreadyout <= 1'b1;
               if (take) begin
                  rd_idx    <= {1'b0, d[0]};
                  ph_rd     <= ~hwrite;           // Writes dropped
                  ph_hit    <= d[2];
                  hreadyout <= 1'b0;
                  state     <= ST_WAIT1;
                  hrdata    <= 32'h00000000;
               end
            end
         endcase
      end
   end
endmodule // bcs_top

/* File: verification/bcs_top_properties.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Readback checks
// ----------------------------------------
module bcs_chk (
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [1:0]  htrans,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   input wire [1:0]  branch_enable,
   input wire [1:0]  auto_disable_en,
   input wire        power_down_request
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_lat; hsel && hready && htrans[1] |=> !hreadyout ##1 !hreadyout ##1 hreadyout; endproperty
   a_lat: assert property (p_lat) else $error("answer timing wrong");
   property p_idle; hreadyout && !(hsel && hready && htrans[1]) |=> hreadyout; endproperty
   a_idle: assert property (p_idle) else $error("wait state without request");
   property p_okay; !hresp; endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_run; $rose(hreadyout) && hrdata[0] |-> |branch_enable; endproperty
   a_run: assert property (p_run) else $error("run bit without enable");
   property p_auto; $rose(hreadyout) && hrdata[1] |-> |auto_disable_en; endproperty
   a_auto: assert property (p_auto) else $error("auto bit without enable");
   property p_wake; $rose(hreadyout) && hrdata[2] |-> power_down_request; endproperty
   a_wake: assert property (p_wake) else $error("wake bit without power-down");
   property p_inv; $rose(hreadyout) && hrdata != 32'h0 |-> hrdata[5] != hrdata[0]; endproperty
   a_inv: assert property (p_inv) else $error("inverse bit wrong");
   property p_rsv; $rose(hreadyout) |-> hrdata[31:6] == 26'h0 && hrdata[4:3] == 2'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
endmodule // bcs_chk
bind bcs_top bcs_chk bcs_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .branch_enable(branch_enable), .auto_disable_en(auto_disable_en),
   .power_down_request(power_down_request));

/* File: verification/bcs_top_tb.sv */
`timescale 1ns/100ps
`include "bcs_regs.vh"
module bcs_top_tb;
   reg         hclk, hresetn, hsel, hwrite, pd, prev;
   reg  [31:0] haddr, hwdata;
   reg  [1:0]  htrans, be, ad, wk;
   wire [31:0] hrdata;
   wire        hreadyout, hresp;
   reg  [32:0] q[$];
   integer     errors, n_compared, i;
   bcs_top bcs_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .branch_enable(be),
      .auto_disable_en(ad), .wake_run_cfg(wk), .power_down_request(pd));
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   task final_report; begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   end endtask
   task cmp_word(input [31:0] exp, input [31:0] got); begin
      n_compared = n_compared + 1;
      if (exp !== got) begin
         errors = errors + 1;
         $display("mismatch hrdata exp %h got %h", exp, got);
      end
   end endtask
   function [31:0] ex(input [31:0] a); reg u; begin
      u = (a == `BCS_U2_BASE);
      ex = (a == `BCS_U1_BASE || u) ? {26'h0, ~be[u], 2'h0, pd & wk[u], ad[u], be[u]} : 32'h0;
   end endfunction
   task bus(input [31:0] a, input w); integer k; begin
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
      q.push_back({~w, ex(a)});
      k = 0;
      @(posedge hclk);
      while (!hreadyout && k < 20) begin k = k + 1; @(posedge hclk); end
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= $urandom;
      @(posedge hclk);
      while (!hreadyout && k < 20) begin k = k + 1; @(posedge hclk); end
      if (k >= 20) begin errors = errors + 1; final_report; end
   end endtask
   // Monitor: each completed read is compared against the oldest note
   always @(posedge hclk) begin
      if (hreadyout && !prev && q.size() > 0) begin
         if (q[0][32]) cmp_word(q[0][31:0], hrdata);
         q.pop_front();
      end
      prev <= hreadyout;
   end
   initial begin
      hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
      htrans = 2'h0; be = 2'h3; ad = 2'h0; wk = 2'h3; pd = 1'b0; prev = 1'b1;
      errors = 0; n_compared = 0;
      i = $urandom(40012);
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      bus(`BCS_U1_BASE, 1'b0);
      bus(`BCS_U2_BASE, 1'b0);
      for (i = 0; i < 40; i = i + 1) begin
         {be, ad, wk, pd} <= 7'($urandom);
         repeat (2) @(posedge hclk);
         bus(i[1] ? `BCS_U2_BASE : `BCS_U1_BASE, i[0]);
         if (i % 4 == 3) bus(`BCS_U1_BASE + 32'h4, 1'b0);
      end
      repeat (4) @(posedge hclk);
      final_report;
   end
endmodule // bcs_top_tb
